// File: evs_defines.vh
// Constants for the event status word block: register map, field
// positions, reset values and counting-mode codes.
// Assumes it is included by bare name from the top module and the testbench.
`ifndef EVS_DEFINES_VH
`define EVS_DEFINES_VH

// ****************************************************************
// Register byte offsets (one aligned 32-bit word each)
// ****************************************************************
`define EVS_OFS_RECORD     8'h00
`define EVS_OFS_LIVE       8'h04
`define EVS_OFS_CTRL       8'h08
`define EVS_OFS_IRQ_STAT   8'h0c
`define EVS_OFS_IRQ_MASK   8'h10
`define EVS_OFS_TALLY      8'h14

// ****************************************************************
// Status word field positions (RECORD and LIVE share them)
// ****************************************************************
`define EVS_B_RUN          0
`define EVS_B_LINK_LOST    1
`define EVS_B_DIAG         2
`define EVS_B_SYNC_LOCK    3
`define EVS_B_SYNC_LOST    4
`define EVS_B_BAD_DATA     5
`define EVS_B_EV_LOST      6
`define EVS_B_PENDING      7
`define EVS_CNT_LSB        8
`define EVS_CNT_MSB        15

// ****************************************************************
// Control register fields
// ****************************************************************
`define EVS_C_LINK_UP      0
`define EVS_C_ACK          1
`define EVS_C_MODE_LSB     2
`define EVS_C_MODE_MSB     4

// ****************************************************************
// Interrupt status and mask bits
// ****************************************************************
`define EVS_I_CAPTURE      0
`define EVS_I_DROP         1
`define EVS_I_DIAG_CHG     2
`define EVS_I_WIDTH        3

// ****************************************************************
// Counting-mode codes; only the quadrature ones use the tally
// ****************************************************************
`define EVS_MODE_PULSE     3'h0
`define EVS_MODE_X1        3'h1
`define EVS_MODE_X2        3'h2
`define EVS_MODE_X4        3'h3

// ****************************************************************
// Reset values, counter wrap value and AHB encodings
// ****************************************************************
`define EVS_CNT_RST        8'h00
`define EVS_CNT_WRAP       8'h01
`define EVS_IRQ_RST        3'h0
`define EVS_CTRL_RST       4'h0
`define EVS_HTRANS_NONSEQ  1'b1
`define EVS_HRESP_OKAY     1'b0

`endif

// File: evs_sync2.v
// Two-flop synchroniser for inputs that arrive from off-chip pins.
// Assumes one clock domain; the first stage is read only by the second.
`timescale 1ns/1ps

module evs_sync2
#(
  parameter WIDTH = 1                  // Number of bits carried
)
(
  // Clock, reset and enable
  input  wire             clk_i,
  input  wire             rst_n_i,
  input  wire             ce_i,
  // Asynchronous input and synchronised output
  input  wire [WIDTH-1:0] async_i,
  output wire [WIDTH-1:0] sync_o
);

  reg [WIDTH-1:0] meta_q;              // First stage, may go metastable
  reg [WIDTH-1:0] sync_q;              // Second stage, safe to use

  // ****************************************************************
  // Synchroniser stages
  // ****************************************************************
  // Both stages freeze with the enable so a stalled block sees no
  // half-moved value
  always @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      meta_q <= {WIDTH{1'b0}};
      sync_q <= {WIDTH{1'b0}};
    end
    else if (ce_i)
    begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;

endmodule

// File: evs_top.v
// Event status word: builds and holds the status part of the event
// record, with an AHB-Lite register slave and one interrupt line.
// Assumes pins run_state_i and the diagnostic inputs are asynchronous;
// the trigger, acknowledge and sync inputs come from logic on clk_i.
//
// Summary of operation
// - Capture run state at trigger: 0 idle, 1 run
// - Drive link-lost flag 0 while connected
// - Diagnostic-present is 1 while any diagnostic active
// - Time-sync-locked is 1 while synchronised to master
// - Time-sync-lost set on timeout after prior lock
// - Count each diagnostic set and clear transition
// - Counter resets to zero, wraps 255 to 1
// - Bad-data flag follows its cause, self-clearing
// - Bad data when tally nonzero in quadrature modes
// - Event-lost flag set when unacknowledged event dropped
//
// Design decisions made here: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps
`include "evs_defines.vh"

module evs_top
#(
  parameter DIAG_W  = 8,               // Number of diagnostic conditions
  parameter TALLY_W = 16               // Width of the phase error tally
)
(
  // Clock, reset and enable
  input  wire               clk_i,
  input  wire               rst_n_i,
  input  wire               ce_i,
  // Pins and neighbouring logic
  input  wire               run_state_i,
  input  wire [DIAG_W-1:0]  diag_cond_i,
  input  wire               sync_locked_i,
  input  wire               sync_timeout_i,
  input  wire [TALLY_W-1:0] phase_error_tally_i,
  input  wire               other_bad_i,
  // Event trigger and acknowledge from the controller side
  input  wire               event_trig_i,
  input  wire               event_ack_i,
  // Latched event record
  output reg                run_state_flag_o,
  output reg                link_lost_flag_o,
  output reg                diag_present_flag_o,
  output reg                time_sync_locked_o,
  output reg                time_sync_lost_o,
  output reg  [7:0]         diag_change_counter_o,
  output reg                bad_data_flag_o,
  output reg                event_lost_flag_o,
  output wire               event_pending_o,
  // Interrupt
  output wire               irq_o,
  // AHB-Lite slave
  input  wire               hsel_i,
  input  wire [7:0]         haddr_i,
  input  wire [1:0]         htrans_i,
  input  wire               hwrite_i,
  input  wire [2:0]         hsize_i,
  input  wire [31:0]        hwdata_i,
  input  wire               hready_i,
  output wire               hreadyout_o,
  output wire               hresp_o,
  output wire [31:0]        hrdata_o
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  wire              run_sync;          // Run state after synchroniser
  wire [DIAG_W-1:0] diag_sync;         // Diagnostics after synchroniser
  reg  [DIAG_W-1:0] diag_prev_q;       // Diagnostics one cycle ago
  reg  [7:0]        cnt_q;             // Live diagnostic change counter
  reg  [7:0]        cnt_d;             // Next counter value
  reg  [8:0]        cnt_sum;           // Counter plus changes, with carry
  reg  [7:0]        n_chg;             // Number of changed conditions
  reg               ever_locked_q;     // Lock has been reached once
  reg               sync_lost_q;       // Lock lost through timeout
  reg               pending_q;         // Record held, not yet acked
  reg               drop_q;            // An event was discarded
  reg               link_up_q;         // Connection established
  reg  [2:0]        mode_q;            // Counting mode
  reg  [`EVS_I_WIDTH-1:0] irq_stat_q;  // Sticky interrupt status
  reg  [`EVS_I_WIDTH-1:0] irq_mask_q;  // Interrupt enables
  reg  [`EVS_I_WIDTH-1:0] irq_ev;      // Interrupt events this cycle
  reg  [31:0]       rdata_q;           // Registered read data
  reg  [31:0]       rdata_d;           // Read data for the next phase
  reg               wr_pend_q;         // Write data phase in progress
  reg  [7:0]        wr_addr_q;         // Address of that write
  wire              live_diag;         // Any diagnostic active now
  wire              quad_mode;         // Mode uses the phase tally
  wire              live_bad;          // Data untrustworthy now
  wire              accept;            // Trigger taken into the record
  wire              drop;              // Trigger discarded
  wire              sw_ack;            // Software acknowledge pulse
  wire              ack;               // Any acknowledge
  wire              addr_ok;           // Valid address phase this edge
  wire [15:0]       live_word;         // Current status, unlatched
  wire [15:0]       rec_word;          // Latched record as a word
  integer           i;                 // Loop index for change count

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  // Run state and diagnostics come straight from pins
  evs_sync2 #(.WIDTH(DIAG_W + 1)) u_sync
  (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .ce_i    (ce_i),
    .async_i ({run_state_i, diag_cond_i}),
    .sync_o  ({run_sync, diag_sync})
  );

  // ****************************************************************
  // Live status terms
  // ****************************************************************
  assign live_diag = |diag_sync;
  // Tally only means something when counting quadrature
  assign quad_mode = (mode_q == `EVS_MODE_X1) ||
                     (mode_q == `EVS_MODE_X2) ||
                     (mode_q == `EVS_MODE_X4);
  // Level with no memory, so it drops as soon as the cause goes
  assign live_bad  = (quad_mode && (|phase_error_tally_i)) ||
                     other_bad_i;

  // ****************************************************************
  // Diagnostic change counter, next value
  // ****************************************************************
  // Several conditions may change in one cycle; each counts once.
  // On carry out of bit 7 the zero slot is skipped by adding one.
  always @*
  begin
    n_chg = 8'h00;
    for (i = 0; i < DIAG_W; i = i + 1)
      n_chg = n_chg + {7'h00, diag_sync[i] ^ diag_prev_q[i]};
    cnt_sum = {1'b0, cnt_q} + {1'b0, n_chg};
    if (cnt_sum[8])
      cnt_d = cnt_sum[7:0] + `EVS_CNT_WRAP;
    else
      cnt_d = cnt_sum[7:0];
  end

  // ****************************************************************
  // Counter, diagnostic history and time sync state
  // ****************************************************************
  always @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      cnt_q         <= `EVS_CNT_RST;
      diag_prev_q   <= {DIAG_W{1'b0}};
      ever_locked_q <= 1'b0;
      sync_lost_q   <= 1'b0;
    end
    else if (ce_i)
    begin
      cnt_q       <= cnt_d;
      diag_prev_q <= diag_sync;
      // Remember a lock so that a later timeout can be told apart
      if (sync_locked_i)
        ever_locked_q <= 1'b1;
      // Regaining lock ends the lost state
      if (sync_locked_i)
        sync_lost_q <= 1'b0;
      else if (sync_timeout_i && ever_locked_q)
        sync_lost_q <= 1'b1;
    end
  end

  // ****************************************************************
  // Event acceptance
  // ****************************************************************
  assign sw_ack  = wr_pend_q && (wr_addr_q == `EVS_OFS_CTRL) &&
                   hwdata_i[`EVS_C_ACK];
  assign ack     = event_ack_i || sw_ack;
  // An ack in the trigger cycle frees the slot for that trigger
  assign accept  = event_trig_i && (!pending_q || ack);
  assign drop    = event_trig_i && pending_q && !ack;

  // ****************************************************************
  // Event record latch
  // ****************************************************************
  // All fields load on the same edge, so the host never sees a mix
  // of two events
  always @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      run_state_flag_o      <= 1'b0;
      link_lost_flag_o      <= 1'b0;
      diag_present_flag_o   <= 1'b0;
      time_sync_locked_o    <= 1'b0;
      time_sync_lost_o      <= 1'b0;
      diag_change_counter_o <= `EVS_CNT_RST;
      bad_data_flag_o       <= 1'b0;
      event_lost_flag_o     <= 1'b0;
      pending_q             <= 1'b0;
      drop_q                <= 1'b0;
    end
    else if (ce_i)
    begin
      if (accept)
      begin
        run_state_flag_o      <= run_sync;
        // Zero while connected; the host replaces it otherwise
        link_lost_flag_o      <= !link_up_q;
        diag_present_flag_o   <= live_diag;
        time_sync_locked_o    <= sync_locked_i;
        time_sync_lost_o      <= sync_lost_q;
        diag_change_counter_o <= cnt_q;
        bad_data_flag_o       <= live_bad;
        event_lost_flag_o     <= drop_q;
        pending_q             <= 1'b1;
        drop_q                <= 1'b0;
      end
      else
      begin
        if (ack)
          pending_q <= 1'b0;
        if (drop)
          drop_q <= 1'b1;
      end
    end
  end

  assign event_pending_o = pending_q;

  // ****************************************************************
  // Interrupt status and output
  // ****************************************************************
  always @*
  begin
    irq_ev                   = {`EVS_I_WIDTH{1'b0}};
    irq_ev[`EVS_I_CAPTURE]   = accept;
    irq_ev[`EVS_I_DROP]      = drop;
    irq_ev[`EVS_I_DIAG_CHG]  = |(diag_sync ^ diag_prev_q);
  end

  // Write-one-to-clear; a new event in the same cycle wins
  always @(posedge clk_i)
  begin
    if (!rst_n_i)
      irq_stat_q <= `EVS_IRQ_RST;
    else if (ce_i)
    begin
      if (wr_pend_q && (wr_addr_q == `EVS_OFS_IRQ_STAT))
        irq_stat_q <= (irq_stat_q &
                       ~hwdata_i[`EVS_I_WIDTH-1:0]) | irq_ev;
      else
        irq_stat_q <= irq_stat_q | irq_ev;
    end
  end

  assign irq_o = |(irq_stat_q & irq_mask_q);

  // ****************************************************************
  // Status words for reading
  // ****************************************************************
  assign live_word = {cnt_q, pending_q, drop_q, live_bad, sync_lost_q,
                      sync_locked_i, live_diag, !link_up_q, run_sync};
  assign rec_word  = {diag_change_counter_o, pending_q,
                      event_lost_flag_o, bad_data_flag_o,
                      time_sync_lost_o, time_sync_locked_o,
                      diag_present_flag_o, link_lost_flag_o,
                      run_state_flag_o};

  // ****************************************************************
  // AHB-Lite slave
  // ****************************************************************
  // No wait states of its own; a low enable stalls the bus instead
  // of letting a transfer slip past frozen registers
  assign addr_ok     = hsel_i && htrans_i[1] == `EVS_HTRANS_NONSEQ &&
                       hready_i;
  assign hreadyout_o = ce_i;
  assign hresp_o     = `EVS_HRESP_OKAY;
  assign hrdata_o    = rdata_q;

  // Read mux; unmapped addresses read as zero
  always @*
  begin
    rdata_d = 32'h0000_0000;
    case (haddr_i)
      `EVS_OFS_RECORD:   rdata_d = {16'h0000, rec_word};
      `EVS_OFS_LIVE:     rdata_d = {16'h0000, live_word};
      `EVS_OFS_CTRL:     rdata_d = {27'h0000000, mode_q, 1'b0, link_up_q};
      `EVS_OFS_IRQ_STAT: rdata_d = {29'h00000000, irq_stat_q};
      `EVS_OFS_IRQ_MASK: rdata_d = {29'h00000000, irq_mask_q};
      `EVS_OFS_TALLY:    rdata_d = {{(32-TALLY_W){1'b0}},
                                    phase_error_tally_i};
      default:           rdata_d = 32'h0000_0000;
    endcase
  end

  // Address phase capture, read data and register writes
  always @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      wr_pend_q  <= 1'b0;
      wr_addr_q  <= 8'h00;
      rdata_q    <= 32'h0000_0000;
      link_up_q  <= 1'b0;
      mode_q     <= `EVS_MODE_PULSE;
      irq_mask_q <= `EVS_IRQ_RST;
    end
    else if (ce_i)
    begin
      // Data phase of a write: control and mask take the data
      if (wr_pend_q)
      begin
        if (wr_addr_q == `EVS_OFS_CTRL)
        begin
          link_up_q <= hwdata_i[`EVS_C_LINK_UP];
          mode_q    <= hwdata_i[`EVS_C_MODE_MSB:`EVS_C_MODE_LSB];
        end
        if (wr_addr_q == `EVS_OFS_IRQ_MASK)
          irq_mask_q <= hwdata_i[`EVS_I_WIDTH-1:0];
      end
      // New address phase
      wr_pend_q <= addr_ok && hwrite_i;
      wr_addr_q <= {haddr_i[7:2], 2'b00};
      if (addr_ok && !hwrite_i)
        rdata_q <= rdata_d;
    end
  end

endmodule

// File: evs_top_chk.sv
// Checker for the event status word: ties the record fields other than
// link-lost and the change counter to their cause at the accepted
// trigger. Sees only the top module's ports.
`timescale 1ns/1ps

module evs_top_chk
#(
  parameter DIAG_W  = 8,
  parameter TALLY_W = 16
)
(
  // Clock and reset
  input wire              clk_i,
  input wire              rst_n_i,
  input wire              ce_i,
  // Causes
  input wire              run_state_i,
  input wire [DIAG_W-1:0] diag_cond_i,
  input wire              sync_locked_i,
  input wire              other_bad_i,
  input wire              event_trig_i,
  input wire              event_ack_i,
  // Record
  input wire              run_state_flag_o,
  input wire              link_lost_flag_o,
  input wire              diag_present_flag_o,
  input wire              time_sync_locked_o,
  input wire              time_sync_lost_o,
  input wire [7:0]        diag_change_counter_o,
  input wire              bad_data_flag_o,
  input wire              event_lost_flag_o,
  input wire              event_pending_o
);
  // ****************************************************************
  // Helper state
  // ****************************************************************
  wire acc_w = event_trig_i && ce_i && (!event_pending_o || event_ack_i);
  wire drop_w = event_trig_i && ce_i && event_pending_o && !event_ack_i;
  reg  drop_q, ever_lock_q;            // Unreported refusal; lock seen
  // Track drops and first lock the way the record should
  always @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      drop_q      <= 1'b0;
      ever_lock_q <= 1'b0;
    end
    else if (ce_i)
    begin
      drop_q      <= drop_w ? 1'b1 : (acc_w ? 1'b0 : drop_q);
      ever_lock_q <= ever_lock_q | sync_locked_i;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_accept;
    acc_w;
  endsequence
  // Pin steady long enough to have crossed the synchroniser
  sequence s_run_steady;
    $past(run_state_i, 3) == run_state_i && $past(run_state_i, 2) ==
    run_state_i && $past(run_state_i) == run_state_i;
  endsequence
  sequence s_diag_on;
    diag_cond_i != 0 && $past(diag_cond_i) != 0 &&
    $past(diag_cond_i, 2) != 0 && $past(diag_cond_i, 3) != 0;
  endsequence
  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_run_capture:
    assert property (s_accept ##0 s_run_steady |=>
      run_state_flag_o == $past(run_state_i)) else $error("run flag wrong");
  a_diag_capture:
    assert property (s_accept ##0 s_diag_on |=> diag_present_flag_o)
    else $error("diag flag not set");
  a_lock_capture:
    assert property (s_accept |=> time_sync_locked_o == $past(sync_locked_i))
    else $error("lock flag wrong");
  a_lost_never:
    assert property (s_accept ##0 !ever_lock_q |=> !time_sync_lost_o)
    else $error("sync lost without prior lock");
  a_bad_other:
    assert property (s_accept ##0 other_bad_i |=> bad_data_flag_o)
    else $error("bad data flag not set");
  a_drop_report:
    assert property (s_accept |=> event_lost_flag_o == $past(drop_q))
    else $error("event lost flag wrong");
  a_pending_set:
    assert property (s_accept |=> event_pending_o) else $error("no pending");
  a_pending_clear:
    assert property (event_ack_i && !event_trig_i && ce_i |=> !event_pending_o)
    else $error("pending not cleared");
  a_record_hold:
    assert property (!acc_w |=> $stable({run_state_flag_o, link_lost_flag_o,
      diag_present_flag_o, time_sync_locked_o, time_sync_lost_o,
      diag_change_counter_o, bad_data_flag_o, event_lost_flag_o}))
    else $error("record changed without trigger");
  a_cnt_no_zero:
    assert property (diag_change_counter_o != 0 |=> diag_change_counter_o != 0)
    else $error("counter returned to zero");
endmodule

bind evs_top evs_top_chk #(.DIAG_W(DIAG_W), .TALLY_W(TALLY_W)) evs_top_chk_inst
(
  .clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .run_state_i(run_state_i),
  .diag_cond_i(diag_cond_i), .sync_locked_i(sync_locked_i),
  .other_bad_i(other_bad_i), .event_trig_i(event_trig_i),
  .event_ack_i(event_ack_i), .run_state_flag_o(run_state_flag_o),
  .link_lost_flag_o(link_lost_flag_o),
  .diag_present_flag_o(diag_present_flag_o),
  .time_sync_locked_o(time_sync_locked_o),
  .time_sync_lost_o(time_sync_lost_o),
  .diag_change_counter_o(diag_change_counter_o),
  .bad_data_flag_o(bad_data_flag_o), .event_lost_flag_o(event_lost_flag_o),
  .event_pending_o(event_pending_o)
);

// File: evs_host_model.sv
// Host controller model: acknowledges held records after a delay and
// keeps its own copy of the link-lost flag. Assumes one clock domain.
`timescale 1ns/1ps

module evs_host_model
(
  // Clock and reset
  input  wire       clk_i,
  input  wire       rst_n_i,
  // Host controls: stall holds off the acknowledge
  input  wire       connected_i,
  input  wire       stall_i,
  input  wire [3:0] delay_i,
  // Record from the device
  input  wire       event_pending_i,
  input  wire       link_lost_flag_i,
  // Acknowledge pulse and host copy
  output reg        event_ack_o,
  output reg        copy_link_lost_o
);
  reg [3:0] wait_q;                    // Cycles spent on the held record
  // One-cycle acknowledge; counter restarts so no second pulse follows
  always @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      event_ack_o      <= 1'b0;
      wait_q           <= 4'h0;
      copy_link_lost_o <= 1'b0;
    end
    else
    begin
      event_ack_o <= 1'b0;
      if (event_ack_o)
        wait_q <= 4'h0;
      else if (event_pending_i && !stall_i && wait_q >= delay_i)
        event_ack_o <= 1'b1;
      else if (event_pending_i && !stall_i)
        wait_q <= wait_q + 4'h1;
      // Without a connection the copy reads link lost whatever came in
      if (event_ack_o)
        copy_link_lost_o <= connected_i ? link_lost_flag_i : 1'b1;
    end
  end
endmodule

// File: evs_top_tb.sv
// Testbench for the event status word: AHB-Lite register access,
// event triggers and a host model. Assumes the defines header.
`timescale 1ns/1ps
`include "evs_defines.vh"

module evs_top_tb;
  logic        clk_i = 0, rst_n_i = 0, run_state_i = 0, sync_locked_i = 0;
  logic        sync_timeout_i = 0, other_bad_i = 0, event_trig_i = 0;
  logic        hsel_i = 0, hwrite_i = 0, connected = 1, stall = 1;
  logic [7:0]  diag_cond_i = 0, haddr_i = 0;
  logic [15:0] phase_error_tally_i = 0;
  logic [1:0]  htrans_i = 0;
  logic [2:0]  hsize_i = 0;
  logic [31:0] hwdata_i = 0, hrdata_o, q;
  wire         run_f, link_f, diag_f, lock_f, lost_f, bad_f, evl_f, pend;
  wire         ack, irq_o, hreadyout_o, hresp_o, copy_link;
  wire [7:0]   cnt_f;
  int          err_count = 0, samples_checked = 0, i;

  always #5 clk_i = ~clk_i;

  evs_top #(.DIAG_W(8), .TALLY_W(16)) evs_top_inst
  (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(1'b1), .run_state_i(run_state_i),
    .diag_cond_i(diag_cond_i), .sync_locked_i(sync_locked_i),
    .sync_timeout_i(sync_timeout_i), .phase_error_tally_i(phase_error_tally_i),
    .other_bad_i(other_bad_i), .event_trig_i(event_trig_i), .event_ack_i(ack),
    .run_state_flag_o(run_f), .link_lost_flag_o(link_f),
    .diag_present_flag_o(diag_f), .time_sync_locked_o(lock_f),
    .time_sync_lost_o(lost_f), .diag_change_counter_o(cnt_f),
    .bad_data_flag_o(bad_f), .event_lost_flag_o(evl_f),
    .event_pending_o(pend), .irq_o(irq_o), .hsel_i(hsel_i), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i),
    .hwdata_i(hwdata_i), .hready_i(hreadyout_o), .hreadyout_o(hreadyout_o),
    .hresp_o(hresp_o), .hrdata_o(hrdata_o)
  );

  evs_host_model evs_host_model_inst
  (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .connected_i(connected),
    .stall_i(stall), .delay_i(4'h3), .event_pending_i(pend),
    .link_lost_flag_i(link_f), .event_ack_o(ack), .copy_link_lost_o(copy_link)
  );

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One single word transfer; waits on the slave's ready, never a count
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel_i <= 1'b1;
    haddr_i <= a;
    htrans_i <= 2'b10;
    hwrite_i <= w;
    hsize_i <= 3'b010;
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
    hsel_i <= 1'b0;
    htrans_i <= 2'b00;
    hwdata_i <= d;
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
    q = hrdata_o;
  endtask

  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    chk(nm, e, q);
  endtask

  // Trigger pulse; free waits until the host has taken the last record
  task automatic fire(input bit free);
    int n;
    for (n = 0; free && pend !== 1'b0 && n < 64; n++)
      @(posedge clk_i);
    chk("fire_wait", 32'h0, {31'h0, pend & free});
    event_trig_i <= 1'b1;
    @(posedge clk_i);
    event_trig_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Watchdog well beyond the expected run of about 900 cycles
  initial
  begin
    #100000;
    err_count++;
    end_of_test;
  end

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial
  begin
    repeat (4) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    chk("reset_record", 32'h0, {cnt_f, evl_f, bad_f, lost_f, pend});
    rdchk("record_reg", `EVS_OFS_RECORD, 32'h0);
    rdchk("unmapped", 8'h1c, 32'h0);
    sync_timeout_i <= 1'b1;
    rdchk("mask_reg", `EVS_OFS_IRQ_MASK, 32'h0);
    fire(1);
    chk("early_rec", 32'h2, {30'h0, link_f, lost_f});
    ahb(1'b1, `EVS_OFS_CTRL, 32'h2);
    $display("test reset done");
    // Capture with the host stalled so the record stays pending
    ahb(1'b1, `EVS_OFS_CTRL, {27'h0, `EVS_MODE_X1, 2'b01});
    run_state_i <= 1'b1;
    sync_locked_i <= 1'b1;
    phase_error_tally_i <= 16'h3;
    diag_cond_i <= 8'h03;
    repeat (6) @(posedge clk_i);
    fire(1);
    rdchk("capture", `EVS_OFS_RECORD, 32'h2ad);
    rdchk("tally_reg", `EVS_OFS_TALLY, 32'h3);
    rdchk("irq_stat", `EVS_OFS_IRQ_STAT, 32'h5);
    ahb(1'b1, `EVS_OFS_IRQ_MASK, 32'h7);
    @(posedge clk_i);
    chk("irq_on", 32'h5, {29'h0, hreadyout_o, hresp_o, irq_o});
    ahb(1'b1, `EVS_OFS_IRQ_STAT, 32'h5);
    @(posedge clk_i);
    chk("irq_off", 32'h0, {31'h0, irq_o});
    $display("test capture done");
    // Trigger while pending is refused and reported on the next record
    fire(0);
    rdchk("drop_stat", `EVS_OFS_IRQ_STAT, 32'h2);
    ahb(1'b1, `EVS_OFS_IRQ_STAT, 32'h2);
    ahb(1'b1, `EVS_OFS_CTRL, {27'h0, `EVS_MODE_PULSE, 2'b01});
    run_state_i <= 1'b0;
    sync_locked_i <= 1'b0;
    stall <= 1'b0;
    repeat (8) @(posedge clk_i);
    fire(1);
    chk("after_drop", 32'h54, {evl_f, bad_f, lost_f, lock_f, diag_f, link_f, run_f});
    ahb(1'b1, `EVS_OFS_CTRL, 32'h1);
    connected <= 1'b0;
    fire(1);
    chk("lost_clear", 32'h0, {evl_f, link_f});
    repeat (8) @(posedge clk_i);
    chk("host_copy", 32'h1, {31'h0, copy_link});
    $display("test drop done");
    // Every counting mode with a nonzero tally, then the other cause
    connected <= 1'b1;
    for (i = 0; i < 4; i++)
    begin
      ahb(1'b1, `EVS_OFS_CTRL, {27'h0, i[2:0], 2'b01});
      fire(1);
      chk("bad_mode", {31'h0, i != 0}, {31'h0, bad_f});
    end
    phase_error_tally_i <= 16'h0;
    other_bad_i <= 1'b1;
    fire(1);
    chk("bad_other", 32'h1, {31'h0, bad_f});
    other_bad_i <= 1'b0;
    fire(1);
    chk("bad_gone", 32'h0, {31'h0, bad_f});
    $display("test bad data done");
    // Count changes up to 255, then the wrap that skips zero
    diag_cond_i <= 8'h00;
    repeat (4) @(posedge clk_i);
    for (i = 0; i < 251; i++)
    begin
      diag_cond_i[0] <= ~diag_cond_i[0];
      repeat (3) @(posedge clk_i);
    end
    ahb(1'b0, `EVS_OFS_LIVE, 32'h0);
    chk("count_255", 32'hff, {24'h0, q[15:8]});
    diag_cond_i[0] <= ~diag_cond_i[0];
    repeat (4) @(posedge clk_i);
    fire(1);
    chk("count_wrap", 32'h1, {24'h0, cnt_f});
    $display("test counter done");
    end_of_test;
  end
endmodule
